// file: verilog/oamu_pkg.sv
// operand address mode unit: shared constants, field positions and state type
// assumes a 16-bit word machine with byte addressing and a same-clock memory port
package oamu_pkg;
  localparam int          WORD_W       = 16;
  localparam int          SPEC_W       = 6;
  localparam int          SPEC_MODE_HI = 5;
  localparam int          SPEC_MODE_LO = 3;
  localparam int          SPEC_REG_HI  = 2;
  localparam int          SPEC_REG_LO  = 0;
  localparam int          BYTE_BIT     = 15;
  localparam int          PSW_MODE_HI  = 15;
  localparam int          PSW_MODE_LO  = 14;
  localparam int          NUM_GEN      = 6;
  localparam int          NUM_SP       = 3;
  localparam logic [2:0]  MODE_REG     = 3'h0;
  localparam logic [2:0]  MODE_REG_DEF = 3'h1;
  localparam logic [2:0]  MODE_AINC    = 3'h2;
  localparam logic [2:0]  MODE_AINC_DEF = 3'h3;
  localparam logic [2:0]  MODE_ADEC    = 3'h4;
  localparam logic [2:0]  MODE_ADEC_DEF = 3'h5;
  localparam logic [2:0]  MODE_INDEX   = 3'h6;
  localparam logic [2:0]  MODE_INDEX_DEF = 3'h7;
  localparam logic [2:0]  REG_STACK    = 3'h6;
  localparam logic [2:0]  REG_PROGRAM  = 3'h7;
  localparam logic [1:0]  PSW_KERNEL   = 2'h0;
  localparam logic [1:0]  PSW_SUPER    = 2'h1;
  localparam logic [1:0]  PSW_USER     = 2'h3;
  localparam logic [1:0]  SP_KERNEL    = 2'h0;
  localparam logic [1:0]  SP_SUPER     = 2'h1;
  localparam logic [1:0]  SP_USER      = 2'h2;
  localparam logic [15:0] STEP_WORD    = 16'h0002;
  localparam logic [15:0] STEP_BYTE    = 16'h0001;
  localparam logic [15:0] EVEN_MASK    = 16'hFFFE;
  localparam logic [15:0] REG_RESET    = 16'h0000;

  typedef enum logic [1:0] {
    OAMU_IDLE,
    OAMU_EXT,
    OAMU_PTR
  } oamu_state_t;
endpackage : oamu_pkg

// file: verilog/oamu_unit.sv
// operand address mode unit: register set, mode decode and operand address sequencing
// assumes the program counter already points past the instruction word at start,
// and a memory port on i_clk that answers each held request with a one-cycle ack
`timescale 1ns/1ps
module oamu_unit (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_start,
  input  wire logic [15:0] i_instr,
  input  wire logic [5:0]  i_spec,
  input  wire logic [15:0] i_psw,
  input  wire logic        i_wr_en,
  input  wire logic [2:0]  i_wr_sel,
  input  wire logic [15:0] i_wr_data,
  input  wire logic        i_mem_ack,
  input  wire logic [15:0] i_mem_rdata,
  output logic             o_busy,
  output logic             o_mem_req,
  output logic [15:0]      o_mem_addr,
  output logic             o_done,
  output logic [15:0]      o_operand_addr,
  output logic [15:0]      o_operand,
  output logic             o_operand_is_reg,
  output logic             o_operand_is_imm,
  output logic             o_byte_op,
  output logic [15:0]      o_pc,
  output logic [15:0]      o_sp
);

  oamu_pkg::oamu_state_t state;
  oamu_pkg::oamu_state_t next_state;
  logic [15:0] gen [oamu_pkg::NUM_GEN];
  logic [15:0] next_gen [oamu_pkg::NUM_GEN];
  logic [15:0] sp [oamu_pkg::NUM_SP];
  logic [15:0] next_sp [oamu_pkg::NUM_SP];
  logic [15:0] pc;
  logic [15:0] next_pc;
  logic        next_mem_req;
  logic [15:0] next_mem_addr;
  logic        next_done;
  logic [15:0] next_operand_addr;
  logic [15:0] next_operand;
  logic        next_is_reg;
  logic        next_is_imm;
  logic        next_byte_op;
  logic [2:0]  cur_mode;
  logic [2:0]  next_mode;
  logic [2:0]  cur_reg;
  logic [2:0]  next_reg;
  logic [2:0]  start_mode;
  logic [2:0]  start_reg;
  logic [15:0] start_val;
  logic [15:0] ext_base;
  logic [15:0] step;
  logic        upd_en;
  logic [2:0]  upd_sel;
  logic [15:0] upd_val;
  logic        take;

  // psw current-mode bits pick the live stack pointer; the unused code falls back to kernel
  function automatic logic [1:0] sp_index(input logic [15:0] psw);
    unique case (psw[oamu_pkg::PSW_MODE_HI:oamu_pkg::PSW_MODE_LO])
      oamu_pkg::PSW_SUPER: sp_index = oamu_pkg::SP_SUPER;
      oamu_pkg::PSW_USER:  sp_index = oamu_pkg::SP_USER;
      default:             sp_index = oamu_pkg::SP_KERNEL;
    endcase
  endfunction : sp_index

  function automatic logic [15:0] reg_read(input logic [2:0] sel, input logic [1:0] spi,
                                           input logic [15:0] pcv, input logic [15:0] g [oamu_pkg::NUM_GEN],
                                           input logic [15:0] s [oamu_pkg::NUM_SP]);
    if (sel == oamu_pkg::REG_PROGRAM) begin
      reg_read = pcv;
    end else if (sel == oamu_pkg::REG_STACK) begin
      reg_read = s[spi];
    end else begin
      reg_read = g[sel];
    end
  endfunction : reg_read

  // stack pointer steps are forced even so interrupt frames stay word aligned
  function automatic logic [15:0] stepped(input logic [15:0] v, input logic [15:0] d,
                                          input logic up, input logic [2:0] sel);
    stepped = up ? v + d : v - d;
    if (sel == oamu_pkg::REG_STACK) begin
      stepped = stepped & oamu_pkg::EVEN_MASK;
    end
  endfunction : stepped

  assign start_mode = i_spec[oamu_pkg::SPEC_MODE_HI:oamu_pkg::SPEC_MODE_LO];
  assign start_reg  = i_spec[oamu_pkg::SPEC_REG_HI:oamu_pkg::SPEC_REG_LO];
  assign start_val  = reg_read(start_reg, sp_index(i_psw), pc, gen, sp);
  // the program counter was advanced when the extension word was requested
  assign ext_base   = reg_read(cur_reg, sp_index(i_psw), pc, gen, sp);
  // byte ops step by one except through the stack pointer or program counter
  assign step       = (i_instr[oamu_pkg::BYTE_BIT] && start_reg < oamu_pkg::REG_STACK)
                      ? oamu_pkg::STEP_BYTE : oamu_pkg::STEP_WORD;
  assign take       = i_start && state == oamu_pkg::OAMU_IDLE;
  assign o_busy     = state != oamu_pkg::OAMU_IDLE;
  assign o_pc       = pc;
  assign o_sp       = sp[sp_index(i_psw)];

  always_comb begin
    next_state        = state;
    next_gen          = gen;
    next_sp           = sp;
    next_pc           = pc;
    next_mem_req      = o_mem_req;
    next_mem_addr     = o_mem_addr;
    next_done         = 1'b0;
    next_operand_addr = o_operand_addr;
    next_operand      = o_operand;
    next_is_reg       = o_operand_is_reg;
    next_is_imm       = o_operand_is_imm;
    next_byte_op      = o_byte_op;
    next_mode         = cur_mode;
    next_reg          = cur_reg;
    upd_en            = 1'b0;
    upd_sel           = start_reg;
    upd_val           = start_val;
    unique case (state)
      oamu_pkg::OAMU_IDLE: begin
        if (take) begin
          next_mode    = start_mode;
          next_reg     = start_reg;
          next_byte_op = i_instr[oamu_pkg::BYTE_BIT];
          next_is_reg  = 1'b0;
          next_is_imm  = 1'b0;
          unique case (start_mode)
            oamu_pkg::MODE_REG: begin
              next_operand = start_val;
              next_is_reg  = 1'b1;
              next_done    = 1'b1;
            end
            oamu_pkg::MODE_REG_DEF: begin
              next_operand_addr = start_val;
              next_done         = 1'b1;
            end
            oamu_pkg::MODE_AINC: begin
              upd_en  = 1'b1;
              upd_val = stepped(start_val, step, 1'b1, start_reg);
              if (start_reg == oamu_pkg::REG_PROGRAM) begin
                next_mem_req  = 1'b1;
                next_mem_addr = start_val;
                next_state    = oamu_pkg::OAMU_EXT;
              end else begin
                next_operand_addr = start_val;
                next_done         = 1'b1;
              end
            end
            oamu_pkg::MODE_AINC_DEF: begin
              upd_en        = 1'b1;
              upd_val       = stepped(start_val, oamu_pkg::STEP_WORD, 1'b1, start_reg);
              next_mem_req  = 1'b1;
              next_mem_addr = start_val;
              next_state    = oamu_pkg::OAMU_PTR;
            end
            oamu_pkg::MODE_ADEC: begin
              upd_en            = 1'b1;
              upd_val           = stepped(start_val, step, 1'b0, start_reg);
              next_operand_addr = upd_val;
              next_done         = 1'b1;
            end
            oamu_pkg::MODE_ADEC_DEF: begin
              upd_en        = 1'b1;
              upd_val       = stepped(start_val, oamu_pkg::STEP_WORD, 1'b0, start_reg);
              next_mem_req  = 1'b1;
              next_mem_addr = upd_val;
              next_state    = oamu_pkg::OAMU_PTR;
            end
            default: begin
              // index forms: fetch the extension word and step the program counter now
              upd_en        = 1'b1;
              upd_sel       = oamu_pkg::REG_PROGRAM;
              upd_val       = pc + oamu_pkg::STEP_WORD;
              next_mem_req  = 1'b1;
              next_mem_addr = pc;
              next_state    = oamu_pkg::OAMU_EXT;
            end
          endcase
        end else if (i_wr_en) begin
          upd_en  = 1'b1;
          upd_sel = i_wr_sel;
          upd_val = i_wr_data;
        end
      end
      oamu_pkg::OAMU_EXT: begin
        if (i_mem_ack) begin
          next_mem_req = 1'b0;
          if (cur_mode == oamu_pkg::MODE_AINC) begin
            next_operand      = i_mem_rdata;
            next_operand_addr = o_mem_addr;
            next_is_imm       = 1'b1;
            next_done         = 1'b1;
            next_state        = oamu_pkg::OAMU_IDLE;
          end else if (cur_mode == oamu_pkg::MODE_INDEX) begin
            next_operand_addr = i_mem_rdata + ext_base;
            next_done         = 1'b1;
            next_state        = oamu_pkg::OAMU_IDLE;
          end else begin
            next_mem_req  = 1'b1;
            next_mem_addr = i_mem_rdata + ext_base;
            next_state    = oamu_pkg::OAMU_PTR;
          end
        end
      end
      oamu_pkg::OAMU_PTR: begin
        if (i_mem_ack) begin
          next_mem_req      = 1'b0;
          next_operand_addr = i_mem_rdata;
          next_done         = 1'b1;
          next_state        = oamu_pkg::OAMU_IDLE;
        end
      end
    endcase
    if (upd_en) begin
      if (upd_sel == oamu_pkg::REG_PROGRAM) begin
        next_pc = upd_val;
      end else if (upd_sel == oamu_pkg::REG_STACK) begin
        next_sp[sp_index(i_psw)] = upd_val;
      end else begin
        next_gen[upd_sel] = upd_val;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state            <= oamu_pkg::OAMU_IDLE;
      gen              <= '{default: oamu_pkg::REG_RESET};
      sp               <= '{default: oamu_pkg::REG_RESET};
      pc               <= oamu_pkg::REG_RESET;
      o_mem_req        <= 1'b0;
      o_mem_addr       <= oamu_pkg::REG_RESET;
      o_done           <= 1'b0;
      o_operand_addr   <= oamu_pkg::REG_RESET;
      o_operand        <= oamu_pkg::REG_RESET;
      o_operand_is_reg <= 1'b0;
      o_operand_is_imm <= 1'b0;
      o_byte_op        <= 1'b0;
      cur_mode         <= oamu_pkg::MODE_REG;
      cur_reg          <= 3'h0;
    end else begin
      state            <= next_state;
      gen              <= next_gen;
      sp               <= next_sp;
      pc               <= next_pc;
      o_mem_req        <= next_mem_req;
      o_mem_addr       <= next_mem_addr;
      o_done           <= next_done;
      o_operand_addr   <= next_operand_addr;
      o_operand        <= next_operand;
      o_operand_is_reg <= next_is_reg;
      o_operand_is_imm <= next_is_imm;
      o_byte_op        <= next_byte_op;
      cur_mode         <= next_mode;
      cur_reg          <= next_reg;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  absolute_fetch_a: assert property (take && start_mode == 3'h3 && start_reg == 3'h7
    |=> o_mem_req && o_mem_addr == $past(pc) && pc == $past(pc) + 16'h0002)
    else $error("absolute mode did not fetch the word after the instruction");
  relative_sum_a: assert property (state == oamu_pkg::OAMU_EXT && i_mem_ack && cur_mode == 3'h6
    |=> o_done && o_operand_addr == $past(i_mem_rdata) + $past(ext_base))
    else $error("index or relative sum wrong");
  deferred_read_a: assert property (state == oamu_pkg::OAMU_EXT && i_mem_ack && cur_mode == 3'h7
    |=> o_mem_req && state == oamu_pkg::OAMU_PTR && o_mem_addr == $past(i_mem_rdata) + $past(ext_base))
    else $error("index deferred did not issue the pointer read");
  pc_advance_a: assert property (take && (start_mode[2:1] == 2'h3 || start_reg == 3'h7 && start_mode[2:1] == 2'h1)
    |=> pc == $past(pc) + 16'h0002)
    else $error("program counter not advanced by two on a fetch");
  sp_step_a: assert property (take && start_mode == 3'h2 && start_reg == 3'h6 && i_instr[15]
    |=> $changed(i_psw) || o_sp == (($past(o_sp) + 16'h0002) & 16'hFFFE))
    else $error("stack pointer byte pop did not step by two");
  sp_even_a: assert property (take && start_mode[2:1] == 2'h2 && start_reg == 3'h6 && i_instr[15]
    |=> $changed(i_psw) || o_sp[0] == 1'b0)
    else $error("stack pointer left odd after byte push");
  reg_def_a: assert property (take && start_mode == 3'h1
    |=> o_done && o_operand_addr == $past(start_val) && !o_busy)
    else $error("register deferred address wrong");
  ptr_result_a: assert property (state == oamu_pkg::OAMU_PTR && i_mem_ack
    |=> o_done && o_operand_addr == $past(i_mem_rdata) ##1 (!o_done || $past(take)))
    else $error("pointer word not taken as operand address");
  adec_def_a: assert property (take && start_mode == 3'h5 && start_reg != 3'h7
    |=> o_mem_req && o_mem_addr == (($past(start_val) - 16'h0002) & ($past(start_reg) == 3'h6 ? 16'hFFFE : 16'hFFFF)))
    else $error("autodecrement deferred pointer wrong");
  byte_flag_a: assert property (take |=> o_byte_op == $past(i_instr[15]))
    else $error("byte flag not taken from bit 15");
  immediate_a: assert property (state == oamu_pkg::OAMU_EXT && i_mem_ack && cur_mode == 3'h2
    |=> o_done && o_operand_is_imm && o_operand == $past(i_mem_rdata))
    else $error("immediate operand not delivered");
  req_hold_a: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
    else $error("memory request dropped before ack");

  imm_seen_c: cover property (o_done && o_operand_is_imm);
  rel_def_c: cover property (state == oamu_pkg::OAMU_EXT && i_mem_ack && cur_mode == 3'h7 && cur_reg == 3'h7
    ##[2:8] o_done);
  sp_push_c: cover property (take && start_mode == 3'h4 && start_reg == 3'h6);
  index_c: cover property (state == oamu_pkg::OAMU_EXT && i_mem_ack && cur_mode == 3'h6);

endmodule : oamu_unit

// file: testbench/oamu_mem_model.sv
// memory model: answers the unit's read requests with a bench-set wait count
// assumes requests are held on i_clk until the ack cycle
`timescale 1ns/1ps
module oamu_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_req,
  input  wire logic [15:0] i_addr,
  input  wire logic [1:0]  i_wait,
  output logic             o_ack,
  output logic [15:0]      o_rdata
);
  logic [1:0]  cnt;
  logic [15:0] last;

  function automatic logic [15:0] mem_word(input logic [15:0] a);
    return {a[7:0], a[15:8]} ^ 16'h3C5A;
  endfunction : mem_word

  // wait of zero acks in the first request cycle
  assign o_ack   = i_req && (cnt == i_wait);
  // idle bus shows the inverted last word so a stale value never matches
  assign o_rdata = o_ack ? mem_word(i_addr) : ~last;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt  <= 2'h0;
      last <= 16'h0000;
    end else begin
      cnt  <= (i_req && !o_ack) ? cnt + 2'h1 : 2'h0;
      last <= o_ack ? o_rdata : last;
    end
  end
endmodule : oamu_mem_model

// file: testbench/test_oamu_unit.sv
// bench for the operand address unit: mode sweeps, stack copies, refused requests
// assumes the memory model answers every read; expectations come from a bench register model
`timescale 1ns/1ps
module test_oamu_unit;
  logic        i_clk, i_sys_rst, i_start, i_wr_en, ack, busy, req, done, is_reg, is_imm, byte_op;
  logic [15:0] i_instr, i_psw, i_wr_data, rdata, maddr, op_addr, operand, pc, sp, e_addr, e_opnd;
  logic [5:0]  i_spec;
  logic [2:0]  i_wr_sel;
  logic [1:0]  mem_wait;
  logic [15:0] rm [8];
  logic [15:0] spc [3];
  int          n_mismatch, num_checks;

  oamu_unit u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_start(i_start), .i_instr(i_instr),
    .i_spec(i_spec), .i_psw(i_psw), .i_wr_en(i_wr_en), .i_wr_sel(i_wr_sel), .i_wr_data(i_wr_data),
    .i_mem_ack(ack), .i_mem_rdata(rdata), .o_busy(busy), .o_mem_req(req), .o_mem_addr(maddr),
    .o_done(done), .o_operand_addr(op_addr), .o_operand(operand), .o_operand_is_reg(is_reg),
    .o_operand_is_imm(is_imm), .o_byte_op(byte_op), .o_pc(pc), .o_sp(sp));
  oamu_mem_model u_mem (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(req), .i_addr(maddr),
    .i_wait(mem_wait), .o_ack(ack), .o_rdata(rdata));

  initial begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end

  function automatic logic [15:0] mem_word(input logic [15:0] a);
    return {a[7:0], a[15:8]} ^ 16'h3C5A;
  endfunction : mem_word

  // psw code 10 falls back to the kernel copy
  function automatic int sp_idx(input logic [15:0] psw);
    return (psw[15:14] == 2'h3) ? 2 : ((psw[15:14] == 2'h1) ? 1 : 0);
  endfunction : sp_idx

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16

  task automatic chk1(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic model_op(input logic b, input int m, input int r);
    logic [15:0] step;
    step   = (b && r < 6) ? 16'h0001 : 16'h0002;
    rm[6]  = spc[sp_idx(i_psw)];
    e_opnd = rm[r];
    e_addr = rm[r];
    if (m == 2 || m == 3) rm[r] = rm[r] + ((m == 3) ? 16'h0002 : step);
    if (m == 4 || m == 5) rm[r] = rm[r] - ((m == 5) ? 16'h0002 : step);
    if (m >= 4) e_addr = rm[r];
    if (m >= 6) begin
      e_addr = mem_word(rm[7]);
      rm[7]  = rm[7] + 16'h0002;
      e_addr = e_addr + rm[r];
    end
    if (m == 3 || m == 5 || m == 7) e_addr = mem_word(e_addr);
    if (m == 2 && r == 7) e_opnd = mem_word(e_addr);
    spc[sp_idx(i_psw)] = rm[6] & 16'hFFFE;
  endtask : model_op

  // waits for the result pulse, bounded, then judges every result output
  task automatic fin(input logic b, input int m, input int r);
    int n;
    n = 0;
    while (done !== 1'h1 && n < 60) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk1("done", 1'h1, done);
    chk1("busy", 1'h0, busy);
    chk1("mem req", 1'h0, req);
    if (m != 0) chk16("operand address", e_addr, op_addr);
    if (m == 0 || (m == 2 && r == 7)) chk16("operand", e_opnd, operand);
    chk1("operand is reg", m == 0, is_reg);
    chk1("operand is imm", m == 2 && r == 7, is_imm);
    chk1("byte op", b, byte_op);
    chk16("pc", rm[7], pc);
    chk16("sp", spc[sp_idx(i_psw)], sp);
  endtask : fin

  task automatic run_op(input logic b, input int m, input int r);
    model_op(b, m, r);
    @(posedge i_clk);
    #1;
    i_start = 1'h1;
    i_instr = {b, 15'h0A00};
    i_spec  = {m[2:0], r[2:0]};
    @(posedge i_clk);
    #1;
    i_start = 1'h0;
    fin(b, m, r);
  endtask : run_op

  task automatic wr(input logic [2:0] sel, input logic [15:0] d);
    @(posedge i_clk);
    #1;
    i_wr_en   = 1'h1;
    i_wr_sel  = sel;
    i_wr_data = d;
    @(posedge i_clk);
    #1;
    i_wr_en = 1'h0;
    if (sel == 3'h6) spc[sp_idx(i_psw)] = d;
    else rm[sel] = d;
  endtask : wr

  task automatic sc_reset;
    chk16("pc", 16'h0000, pc);
    chk16("sp", 16'h0000, sp);
    chk1("busy", 1'h0, busy);
    chk1("mem req", 1'h0, req);
    chk1("done", 1'h0, done);
  endtask : sc_reset

  // every mode on every register; mode 0 again at the end reads back the register
  task automatic sc_sweep(input logic b, input logic [1:0] w);
    mem_wait = w;
    for (int r = 0; r < 8; r++) begin
      wr(r[2:0], {4'h1, r[3:0], 8'h40});
      for (int m = 0; m < 9; m++) run_op(b, m % 8, r);
    end
  endtask : sc_sweep

  task automatic sc_stack;
    for (int k = 0; k < 3; k++) begin
      i_psw = {(k == 2) ? 2'h3 : k[1:0], 14'h0000};
      wr(3'h6, {k[3:0], 12'h200});
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      #1;
      i_psw = {k[1:0], 14'h0000};
      @(negedge i_clk);
      chk16("sp copy", spc[sp_idx(i_psw)], sp);
    end
    @(posedge i_clk);
    #1;
    i_psw = 16'hC000;
    run_op(1'h1, 4, 6);
    run_op(1'h1, 2, 6);
    run_op(1'h0, 6, 6);
    i_psw = 16'h0000;
    @(negedge i_clk);
    chk16("kernel sp", 16'h0200, sp);
    @(posedge i_clk);
    #1;
    i_psw = 16'h4000;
    @(negedge i_clk);
    chk16("super sp", 16'h1200, sp);
    @(posedge i_clk);
    #1;
    i_psw = 16'h0000;
  endtask : sc_stack

  // start and write while busy are both ignored; a new start in the done cycle is taken
  task automatic sc_refuse;
    mem_wait = 2'h3;
    model_op(1'h0, 7, 1);
    @(posedge i_clk);
    #1;
    i_start = 1'h1;
    i_instr = 16'h0A00;
    i_spec  = 6'h39;
    @(posedge i_clk);
    #1;
    i_spec    = 6'h01;
    i_wr_en   = 1'h1;
    i_wr_sel  = 3'h1;
    i_wr_data = 16'hFFFF;
    @(posedge i_clk);
    #1;
    i_start = 1'h0;
    i_wr_en = 1'h0;
    fin(1'h0, 7, 1);
    model_op(1'h0, 0, 1);
    i_start = 1'h1;
    i_spec  = 6'h01;
    @(posedge i_clk);
    #1;
    i_start = 1'h0;
    fin(1'h0, 0, 1);
  endtask : sc_refuse

  // reset in the middle of a two-read sequence; all state returns to zero
  task automatic sc_mid_reset;
    mem_wait = 2'h3;
    @(posedge i_clk);
    #1;
    i_start = 1'h1;
    i_instr = 16'h0A00;
    i_spec  = 6'h3F;
    @(posedge i_clk);
    #1;
    i_start = 1'h0;
    @(posedge i_clk);
    #1;
    chk1("busy", 1'h1, busy);
    chk1("mem req", 1'h1, req);
    i_sys_rst = 1'h1;
    @(posedge i_clk);
    #1;
    i_sys_rst = 1'h0;
    foreach (rm[k]) rm[k] = 16'h0000;
    foreach (spc[k]) spc[k] = 16'h0000;
    sc_reset;
    run_op(1'h0, 0, 7);
  endtask : sc_mid_reset

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  initial begin
    n_mismatch = 0;
    num_checks = 0;
    i_sys_rst  = 1'h1;
    i_start    = 1'h0;
    i_wr_en    = 1'h0;
    i_instr    = 16'h0000;
    i_spec     = 6'h00;
    i_psw      = 16'h0000;
    i_wr_sel   = 3'h0;
    i_wr_data  = 16'h0000;
    mem_wait   = 2'h0;
    foreach (rm[k]) rm[k] = 16'h0000;
    foreach (spc[k]) spc[k] = 16'h0000;
    repeat (12) @(posedge i_clk);
    #1;
    i_sys_rst = 1'h0;
    sc_reset;
    sc_sweep(1'h0, 2'h0);
    sc_sweep(1'h1, 2'h1);
    sc_stack;
    sc_refuse;
    sc_mid_reset;
    sc_sweep(1'h1, 2'h3);
    test_done;
  end

  // whole run is under a thousand cycles; this limit only catches a hang
  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    $display("ERROR watchdog expected finish seen timeout");
    test_done;
  end
endmodule : test_oamu_unit
